//--- usd_byte_fifo.sv
// byte queue with a one-entry overwrite mode for fifos-off operation
module usd_byte_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         rst,
  // control
  input  wire logic         flush,
  input  wire logic         single,
  // fill side
  input  wire logic         push,
  input  wire logic [W-1:0] din,
  // drain side
  input  wire logic         pop,
  output logic      [W-1:0] dout,
  output logic              empty,
  output logic              full
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  localparam int CW = $clog2(D + 1);

  logic [W-1:0]  mem [D];
  logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic          do_pop, do_push, ovw;

  function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
    return (p == AW'(D - 1)) ? '0 : p + AW'(1);
  endfunction : inc

  ////////////////////////////////////////////////////////////////
  // single mode holds one entry; a later push replaces it
  assign empty   = (cnt_reg == '0);
  assign full    = single ? !empty : (cnt_reg == CW'(D));
  assign do_pop  = pop & !empty;
  assign do_push = push & (!full | do_pop);
  assign ovw     = push & full & single & !do_pop;
  assign dout    = mem[rd_reg];

  // pointer and count update
  always_comb begin
    wr_next  = wr_reg;
    rd_next  = rd_reg;
    cnt_next = cnt_reg;
    if (flush) begin
      wr_next  = '0;
      rd_next  = '0;
      cnt_next = '0;
    end else begin
      if (do_push) wr_next = inc(wr_reg);
      if (do_pop)  rd_next = inc(rd_reg);
      if (do_push & !do_pop) cnt_next = cnt_reg + CW'(1);
      if (do_pop & !do_push) cnt_next = cnt_reg - CW'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
    end
  end

  // storage; cleared on reset so a read of a never-filled queue gives zero, not unknowns
  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int i = 0; i < D; i++) mem[i] <= '0;
    end else if (!flush && (do_push || ovw)) begin
      mem[ovw ? rd_reg : wr_reg] <= din;
    end
  end
endmodule : usd_byte_fifo

//--- usd_peer.sv
// remote serial peer: sends and collects 8n1 frames on the plain or infrared line
module usd_peer #(
  parameter int CPB = 4
) (
  // clock
  input  wire logic mclk,
  // line select, high for infrared
  input  wire logic ir,
  // lines from the port
  input  wire logic sout,
  input  wire logic sir_out_n,
  // lines to the port, idle high like a pulled-up line
  output logic      sin,
  output logic      sir_in
);
  timeunit 1ns;
  timeprecision 1ps;

  // the line being listened to; infrared is level coded, low is a 0 bit
  wire logic rx_line = ir ? sir_out_n : sout;

  initial begin
    sin = 1'b1;
    sir_in = 1'b1;
  end

  ////////////////////////////////////////////////////////////////
  // send one frame, lsb first, on the selected line only
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      if (ir) sir_in <= f[i];
      else sin <= f[i];
      repeat (CPB) @(posedge mclk);
    end
  endtask : send

  ////////////////////////////////////////////////////////////////
  // collect one frame; samples mid-bit, returns mid stop bit
  task automatic get(output logic [7:0] b);
    int n;
    n = 0;
    b = 8'hxx;
    // bounded wait so a silent port cannot hang the peer
    while (rx_line !== 1'b0 && n < 3000) begin
      @(posedge mclk);
      n++;
    end
    repeat (CPB / 2) @(posedge mclk);
    for (int i = 0; i < 8; i++) begin
      repeat (CPB) @(posedge mclk);
      b[i] = rx_line;
    end
    repeat (CPB) @(posedge mclk);
  endtask : get
endmodule : usd_peer

//--- usd_pkg.sv
// constants and types shared by the shadow data port
package usd_pkg;
  ////////////////////////////////////////////////////////////////
  // register map (byte addresses)
  localparam logic [31:0] SLOT6_ADDR  = 32'h5000_1048;
  localparam int          SLOT6_INDEX = 6;
  localparam int          NUM_SLOTS   = 16;
  localparam logic [31:0] ALIAS_BASE  = SLOT6_ADDR - 32'(SLOT6_INDEX * 4);
  localparam logic [31:0] ALIAS_SPAN  = 32'(NUM_SLOTS * 4);
  localparam logic [31:0] CTRL_ADDR   = 32'h5000_1100;
  localparam logic [31:0] STAT_ADDR   = 32'h5000_1104;
  localparam int          DATA_W      = 8;
  localparam logic [7:0]  DATA_RST    = 8'h00;

  ////////////////////////////////////////////////////////////////
  // field positions
  localparam int CTRL_FIFO_EN_BIT = 0;
  localparam int CTRL_IR_BIT      = 1;
  localparam int ST_RX_VALID_BIT  = 0;
  localparam int ST_OVERRUN_BIT   = 1;
  localparam int ST_THR_EMPTY_BIT = 5;
  localparam int ST_TX_IDLE_BIT   = 6;

  ////////////////////////////////////////////////////////////////
  // defaults and counts
  localparam int DEF_FIFO_DEPTH   = 16;
  localparam int DEF_CLKS_PER_BIT = 16;
  localparam int LAST_DATA_BIT    = DATA_W - 1;

  // serial engine states, gray along idle-start-data-stop
  typedef enum logic [1:0] {
    USD_IDLE  = 2'h0,
    USD_START = 2'h1,
    USD_DATA  = 2'h3,
    USD_STOP  = 2'h2
  } usd_ser_e;

  typedef struct packed {
    logic ir_mode;
    logic fifo_en;
  } usd_ctrl_s;

  typedef struct packed {
    logic tx_idle;
    logic thr_empty;
    logic overrun;
    logic rx_valid;
  } usd_stat_s;

  localparam usd_ctrl_s CTRL_RST = '{ir_mode: 1'b0, fifo_en: 1'b0};
endpackage : usd_pkg

//--- usd_shadow_port.sv
// apb shadow data alias with serial and infrared line engines
// Operation
// - all sixteen alias words decode to the same receive/transmit data path
// - read returns received byte in low eight bits, serial or infrared input
// - read data only valid while receive-data-valid flag is set
// - fifos off: new character overwrites unread byte and flags overrun
// - fifos on: read returns the head of the receive fifo
// - receive fifo full: keep contents, drop new character, flag overrun
// - written byte is sent on serial output or active-low infrared output
// - fifos off: one write clears the transmit-holding-empty flag
// - fifos off: further writes before empty flag returns replace pending byte
// - fifos on: accept writes up to fifo depth, sixteen by default
// - transmit fifo full: written data dropped, queue unchanged
module usd_shadow_port #(
  parameter int FIFO_DEPTH   = usd_pkg::DEF_FIFO_DEPTH,
  parameter int CLKS_PER_BIT = usd_pkg::DEF_CLKS_PER_BIT
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // line side
  input  wire logic        sin,
  input  wire logic        sir_in,
  output logic             sout,
  output logic             sir_out_n,
  // flags to the rest of the uart
  output logic             receive_data_valid_flag,
  output logic             transmit_holding_empty_flag,
  output logic             overrun_error,
  output logic             fifo_enabled
);
  localparam int CW = $clog2(CLKS_PER_BIT);
  localparam logic [CW-1:0] BIT_LAST  = CW'(CLKS_PER_BIT - 1);
  localparam logic [CW-1:0] HALF_LAST = CW'(CLKS_PER_BIT / 2 - 1);
  localparam logic [2:0]    BITN_LAST = 3'(usd_pkg::LAST_DATA_BIT);

  function automatic logic is_alias(input logic [31:0] a);
    return (a >= usd_pkg::ALIAS_BASE) && (a < usd_pkg::ALIAS_BASE + usd_pkg::ALIAS_SPAN)
           && (a[1:0] == 2'h0);
  endfunction : is_alias

  ////////////////////////////////////////////////////////////////
  // declarations
  logic [31:0]        prdata_reg, prdata_next;
  logic               pready_reg, pready_next, pslverr_reg, pslverr_next;
  usd_pkg::usd_ctrl_s ctrl_reg, ctrl_next;
  logic               ovr_reg, ovr_next;
  usd_pkg::usd_stat_s stat_live, stat_reg;
  logic               setup_done, acc_end, hit_alias, hit_ctrl, hit_stat, hit_any;
  logic               ctrl_wr, flush, ovr_clr, rx_drop;
  logic [7:0]         rx_dout, tx_dout;
  logic               rx_empty, rx_full, tx_empty, tx_full;
  logic               rx_push, rx_pop, tx_push, tx_pop;
  usd_pkg::usd_ser_e  rx_st_reg, rx_st_next, tx_st_reg, tx_st_next;
  logic [CW-1:0]      rx_cnt_reg, rx_cnt_next, tx_cnt_reg, tx_cnt_next;
  logic [2:0]         rx_bit_reg, rx_bit_next, tx_bit_reg, tx_bit_next;
  logic [7:0]         rx_sh_reg, rx_sh_next, tx_sh_reg, tx_sh_next;
  logic               rx_in, tx_line, sout_reg, sout_next, sirn_reg, sirn_next;

  ////////////////////////////////////////////////////////////////
  // bus decode; one wait state so every answer comes from a flop
  assign setup_done = psel & penable & !pready_reg;
  assign acc_end    = psel & penable & pready_reg;
  assign hit_alias  = is_alias(paddr);
  assign hit_ctrl   = (paddr == usd_pkg::CTRL_ADDR);
  assign hit_stat   = (paddr == usd_pkg::STAT_ADDR);
  assign hit_any    = hit_alias | hit_ctrl | hit_stat;

  // side effects: reads pop when data is latched, writes at completion
  assign rx_pop  = setup_done & !pwrite & hit_alias;
  assign tx_push = acc_end & pwrite & hit_alias;
  assign ctrl_wr = acc_end & pwrite & hit_ctrl;
  assign ovr_clr = setup_done & !pwrite & hit_stat;
  // changing the fifo mode empties both queues
  assign flush   = ctrl_wr & (pwdata[usd_pkg::CTRL_FIFO_EN_BIT] != ctrl_reg.fifo_en);

  // live status view
  always_comb begin
    stat_live.rx_valid  = !rx_empty;
    stat_live.overrun   = ovr_reg;
    stat_live.thr_empty = tx_empty;
    stat_live.tx_idle   = tx_empty & (tx_st_reg == usd_pkg::USD_IDLE);
  end

  // apb answer and control register next values
  always_comb begin
    pready_next  = setup_done;
    prdata_next  = prdata_reg;
    pslverr_next = pslverr_reg;
    ctrl_next    = ctrl_reg;
    if (setup_done) begin
      prdata_next  = '0;
      pslverr_next = !hit_any;
      if (!pwrite && hit_alias) begin
        prdata_next = 32'(rx_dout);
      end else if (!pwrite && hit_ctrl) begin
        prdata_next[usd_pkg::CTRL_FIFO_EN_BIT] = ctrl_reg.fifo_en;
        prdata_next[usd_pkg::CTRL_IR_BIT]      = ctrl_reg.ir_mode;
      end else if (!pwrite && hit_stat) begin
        prdata_next[usd_pkg::ST_RX_VALID_BIT]  = stat_live.rx_valid;
        prdata_next[usd_pkg::ST_OVERRUN_BIT]   = stat_live.overrun;
        prdata_next[usd_pkg::ST_THR_EMPTY_BIT] = stat_live.thr_empty;
        prdata_next[usd_pkg::ST_TX_IDLE_BIT]   = stat_live.tx_idle;
      end
    end
    if (ctrl_wr) begin
      ctrl_next.fifo_en = pwdata[usd_pkg::CTRL_FIFO_EN_BIT];
      ctrl_next.ir_mode = pwdata[usd_pkg::CTRL_IR_BIT];
    end
  end

  // overrun is sticky; a new event beats a clear by status read
  assign rx_drop = rx_push & rx_full & !rx_pop;
  always_comb begin
    ovr_next = rx_drop | (ovr_reg & !ovr_clr);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      prdata_reg  <= '0;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      ctrl_reg    <= usd_pkg::CTRL_RST;
      ovr_reg     <= 1'b0;
      stat_reg    <= '0;
    end else begin
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
      ctrl_reg    <= ctrl_next;
      ovr_reg     <= ovr_next;
      stat_reg    <= stat_live;
    end
  end

  ////////////////////////////////////////////////////////////////
  // queues; fifos off shrinks each to one overwritable entry
  usd_byte_fifo #(.W(usd_pkg::DATA_W), .D(FIFO_DEPTH)) u_rx_q (
    .mclk  (mclk),
    .rst   (rst),
    .flush (flush),
    .single(!ctrl_reg.fifo_en),
    .push  (rx_push),
    .din   (rx_sh_reg),
    .pop   (rx_pop),
    .dout  (rx_dout),
    .empty (rx_empty),
    .full  (rx_full)
  );

  usd_byte_fifo #(.W(usd_pkg::DATA_W), .D(FIFO_DEPTH)) u_tx_q (
    .mclk  (mclk),
    .rst   (rst),
    .flush (flush),
    .single(!ctrl_reg.fifo_en),
    .push  (tx_push),
    .din   (pwdata[usd_pkg::DATA_W-1:0]),
    .pop   (tx_pop),
    .dout  (tx_dout),
    .empty (tx_empty),
    .full  (tx_full)
  );

  ////////////////////////////////////////////////////////////////
  // receiver: 8 data bits, no parity, one stop; bad stop is dropped
  assign rx_in = ctrl_reg.ir_mode ? sir_in : sin;
  always_comb begin
    rx_st_next  = rx_st_reg;
    rx_cnt_next = rx_cnt_reg + CW'(1);
    rx_bit_next = rx_bit_reg;
    rx_sh_next  = rx_sh_reg;
    rx_push     = 1'b0;
    case (rx_st_reg)
      usd_pkg::USD_IDLE: begin
        rx_cnt_next = '0;
        if (!rx_in) rx_st_next = usd_pkg::USD_START;
      end
      usd_pkg::USD_START: begin
        // confirm start at mid-bit to reject glitches
        if (rx_cnt_reg == HALF_LAST) begin
          rx_cnt_next = '0;
          rx_bit_next = '0;
          rx_st_next  = rx_in ? usd_pkg::USD_IDLE : usd_pkg::USD_DATA;
        end
      end
      usd_pkg::USD_DATA: begin
        if (rx_cnt_reg == BIT_LAST) begin
          rx_cnt_next = '0;
          rx_sh_next  = {rx_in, rx_sh_reg[7:1]};
          rx_bit_next = rx_bit_reg + 3'h1;
          if (rx_bit_reg == BITN_LAST) rx_st_next = usd_pkg::USD_STOP;
        end
      end
      usd_pkg::USD_STOP: begin
        if (rx_cnt_reg == BIT_LAST) begin
          rx_push    = rx_in;
          rx_st_next = usd_pkg::USD_IDLE;
        end
      end
      default: rx_st_next = usd_pkg::USD_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rx_st_reg  <= usd_pkg::USD_IDLE;
      rx_cnt_reg <= '0;
      rx_bit_reg <= '0;
      rx_sh_reg  <= usd_pkg::DATA_RST;
    end else begin
      rx_st_reg  <= rx_st_next;
      rx_cnt_reg <= rx_cnt_next;
      rx_bit_reg <= rx_bit_next;
      rx_sh_reg  <= rx_sh_next;
    end
  end

  ////////////////////////////////////////////////////////////////
  // transmitter: takes the queue head as soon as it is idle
  always_comb begin
    tx_st_next  = tx_st_reg;
    tx_cnt_next = tx_cnt_reg + CW'(1);
    tx_bit_next = tx_bit_reg;
    tx_sh_next  = tx_sh_reg;
    tx_pop      = 1'b0;
    case (tx_st_reg)
      usd_pkg::USD_IDLE: begin
        tx_cnt_next = '0;
        if (!tx_empty) begin
          tx_pop     = 1'b1;
          tx_sh_next = tx_dout;
          tx_st_next = usd_pkg::USD_START;
        end
      end
      usd_pkg::USD_START: begin
        if (tx_cnt_reg == BIT_LAST) begin
          tx_cnt_next = '0;
          tx_bit_next = '0;
          tx_st_next  = usd_pkg::USD_DATA;
        end
      end
      usd_pkg::USD_DATA: begin
        if (tx_cnt_reg == BIT_LAST) begin
          tx_cnt_next = '0;
          tx_sh_next  = {1'b0, tx_sh_reg[7:1]};
          tx_bit_next = tx_bit_reg + 3'h1;
          if (tx_bit_reg == BITN_LAST) tx_st_next = usd_pkg::USD_STOP;
        end
      end
      usd_pkg::USD_STOP: begin
        if (tx_cnt_reg == BIT_LAST) tx_st_next = usd_pkg::USD_IDLE;
      end
      default: tx_st_next = usd_pkg::USD_IDLE;
    endcase
  end

  // line level; the unused output rests at its idle level
  always_comb begin
    tx_line = 1'b1;
    if (tx_st_reg == usd_pkg::USD_START) tx_line = 1'b0;
    if (tx_st_reg == usd_pkg::USD_DATA)  tx_line = tx_sh_reg[0];
    sout_next = ctrl_reg.ir_mode ? 1'b1 : tx_line;
    sirn_next = ctrl_reg.ir_mode ? tx_line : 1'b1;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      tx_st_reg  <= usd_pkg::USD_IDLE;
      tx_cnt_reg <= '0;
      tx_bit_reg <= '0;
      tx_sh_reg  <= usd_pkg::DATA_RST;
      sout_reg   <= 1'b1;
      sirn_reg   <= 1'b1;
    end else begin
      tx_st_reg  <= tx_st_next;
      tx_cnt_reg <= tx_cnt_next;
      tx_bit_reg <= tx_bit_next;
      tx_sh_reg  <= tx_sh_next;
      sout_reg   <= sout_next;
      sirn_reg   <= sirn_next;
    end
  end

  ////////////////////////////////////////////////////////////////
  // outputs
  assign prdata                      = prdata_reg;
  assign pready                      = pready_reg;
  assign pslverr                     = pslverr_reg;
  assign sout                        = sout_reg;
  assign sir_out_n                   = sirn_reg;
  assign receive_data_valid_flag     = stat_reg.rx_valid;
  assign transmit_holding_empty_flag = stat_reg.thr_empty;
  assign overrun_error               = stat_reg.overrun;
  assign fifo_enabled                = ctrl_reg.fifo_en;

  ////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_alias_ok;
    setup_done && hit_alias |=> pready_reg && !pslverr_reg;
  endproperty
  a_alias_ok: assert property (p_alias_ok) else $error("alias slot not answered cleanly");

  property p_read_head;
    setup_done && !pwrite && hit_alias |=> prdata_reg[7:0] == $past(rx_dout);
  endproperty
  a_read_head: assert property (p_read_head) else $error("read byte is not the queue head");

  property p_upper_zero;
    pready_reg && hit_alias && !pwrite |-> prdata_reg[31:8] == '0;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("reserved read bits not zero");

  property p_valid_after_rx;
    rx_push && !rx_pop && !flush |=> !rx_empty ##1 stat_reg.rx_valid;
  endproperty
  a_valid_after_rx: assert property (p_valid_after_rx) else $error("valid flag missing after receive");

  property p_overrun_off;
    !ctrl_reg.fifo_en && rx_drop && !flush |=> ovr_reg && rx_dout == $past(rx_sh_reg);
  endproperty
  a_overrun_off: assert property (p_overrun_off) else $error("overwrite or overrun missing");

  property p_overrun_on;
    ctrl_reg.fifo_en && rx_drop && !flush |=> ovr_reg && rx_full && $stable(rx_dout);
  endproperty
  a_overrun_on: assert property (p_overrun_on) else $error("full receive queue disturbed");

  property p_transmit_holding_empty_flag_clear;
    !ctrl_reg.fifo_en && tx_empty && tx_push && !flush |=> !tx_empty ##1 !stat_reg.thr_empty;
  endproperty
  a_transmit_holding_empty_flag_clear: assert property (p_transmit_holding_empty_flag_clear) else $error("write did not clear empty flag");

  property p_replace;
    !ctrl_reg.fifo_en && tx_push && !tx_empty && !tx_pop && !flush
      |=> tx_dout == $past(pwdata[7:0]);
  endproperty
  a_replace: assert property (p_replace) else $error("pending byte not replaced");

  property p_tx_drop;
    ctrl_reg.fifo_en && tx_full && tx_push && !tx_pop && !flush |=> tx_full && $stable(tx_dout);
  endproperty
  a_tx_drop: assert property (p_tx_drop) else $error("full transmit queue disturbed");

  property p_start_bit;
    tx_st_reg == usd_pkg::USD_START && !ctrl_reg.ir_mode && $stable(ctrl_reg)
      |=> !sout_reg && sirn_reg;
  endproperty
  a_start_bit: assert property (p_start_bit) else $error("start bit not driven low");

  c_rx_overrun_fifo: cover property (ctrl_reg.fifo_en && rx_drop);
  c_tx_full:         cover property (ctrl_reg.fifo_en && tx_full);
  c_status_read:     cover property (ovr_clr && ovr_reg);
endmodule : usd_shadow_port

//--- usd_shadow_port_bench.sv
// self-checking bench for the shadow data port
module usd_shadow_port_bench;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int          CPB  = 4;
  localparam int          DEP  = 4;
  localparam logic [31:0] BASE = usd_pkg::ALIAS_BASE;
  localparam logic [31:0] ST   = usd_pkg::STAT_ADDR;
  localparam logic [31:0] CT   = usd_pkg::CTRL_ADDR;

  logic        mclk       = 1'b0;
  logic        rst        = 1'b1;
  logic        psel       = 1'b0;
  logic        penable    = 1'b0;
  logic        pwrite     = 1'b0;
  logic        ir_mode    = 1'b0;
  logic [31:0] paddr      = 32'h0;
  logic [31:0] pwdata     = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready;
  logic        pslverr;
  logic        err_q;
  logic        sin;
  logic        sir_in;
  logic        sout;
  logic        sir_out_n;
  logic        rx_valid_flag;
  logic        tx_empty_flag;
  logic        ovr_flag;
  logic        fifo_en_flag;
  logic [7:0]  got [6];
  int          num_errors = 0;
  int          n_tests    = 0;
  int          cyc        = 0;

  always #2 mclk = ~mclk;

  usd_shadow_port #(.FIFO_DEPTH(DEP), .CLKS_PER_BIT(CPB)) usd_shadow_port_inst (
    .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sin(sin),
    .sir_in(sir_in), .sout(sout), .sir_out_n(sir_out_n), .receive_data_valid_flag(rx_valid_flag),
    .transmit_holding_empty_flag(tx_empty_flag), .overrun_error(ovr_flag), .fifo_enabled(fifo_en_flag)
  );

  usd_peer #(.CPB(CPB)) usd_peer_inst (
    .mclk(mclk), .ir(ir_mode), .sout(sout), .sir_out_n(sir_out_n), .sin(sin), .sir_in(sir_in)
  );

  ////////////////////////////////////////////////////////////////
  // report and stop
  task test_done;
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : test_done

  task chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("FAIL t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  // one apb transfer, entered just after a rising edge; holds until pready
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // no local limit: only the hang guard ends a stuck wait
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge so no signal is driven twice in a time step
    @(posedge mclk);
  endtask : apb

  // hang guard, well above the less than one thousand cycles the run needs
  always @(posedge mclk) begin
    cyc++;
    if (cyc > 20000) begin
      num_errors++;
      test_done;
    end
  end

  ////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    apb(1'b0, usd_pkg::SLOT6_ADDR, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, ST, 32'h0);
    chk(rd & 32'h63, 32'h60);
    chk({28'h0, fifo_en_flag, ovr_flag, tx_empty_flag, rx_valid_flag}, 32'h2);
    apb(1'b0, 32'h5000_1070, 32'h0);
    chk({31'h0, err_q}, 32'h1);
    // fifos off: receive, then overwrite with overrun
    usd_peer_inst.send(8'ha5);
    repeat (4) @(posedge mclk);
    apb(1'b0, ST, 32'h0);
    chk(rd & 32'h3, 32'h1);
    apb(1'b0, BASE, 32'h0);
    chk(rd, 32'ha5);
    usd_peer_inst.send(8'ha1);
    usd_peer_inst.send(8'ha2);
    repeat (4) @(posedge mclk);
    chk({28'h0, fifo_en_flag, ovr_flag, tx_empty_flag, rx_valid_flag}, 32'h7);
    apb(1'b0, ST, 32'h0);
    chk(rd & 32'h3, 32'h3);
    apb(1'b0, BASE + 32'd36, 32'h0);
    chk(rd, 32'ha2);
    // fifos off: held byte replaced while the shifter is busy
    fork
      begin
        usd_peer_inst.get(got[0]);
        usd_peer_inst.get(got[1]);
      end
      begin
        apb(1'b1, BASE + 32'd60, 32'hffff_ff11);
        apb(1'b1, usd_pkg::SLOT6_ADDR, 32'h22);
        apb(1'b0, ST, 32'h0);
        chk({31'h0, rd[5]}, 32'h0);
        apb(1'b1, BASE + 32'd4, 32'h33);
      end
    join
    chk({24'h0, got[0]}, 32'h11);
    chk({24'h0, got[1]}, 32'h33);
    // fifos on: fill receive queue past its depth
    apb(1'b1, CT, 32'h1);
    for (int i = 0; i < 5; i++) usd_peer_inst.send(8'hc0 + 8'(i));
    repeat (4) @(posedge mclk);
    chk({28'h0, fifo_en_flag, ovr_flag, tx_empty_flag, rx_valid_flag}, 32'hf);
    apb(1'b0, ST, 32'h0);
    chk(rd & 32'h3, 32'h3);
    for (int i = 0; i < DEP; i++) begin
      apb(1'b0, BASE + 32'(4 * i), 32'h0);
      chk(rd, 32'hc0 + 32'(i));
    end
    apb(1'b0, ST, 32'h0);
    chk(rd & 32'h1, 32'h0);
    // fifos on: one byte in the shifter, depth queued, the last dropped
    fork
      for (int i = 0; i < 5; i++) usd_peer_inst.get(got[i]);
      begin
        for (int i = 0; i < 6; i++) apb(1'b1, BASE + 32'(4 * i), 32'hd0 + 32'(i));
        apb(1'b0, ST, 32'h0);
        chk({31'h0, rd[5]}, 32'h0);
      end
    join
    for (int i = 0; i < 5; i++) chk({24'h0, got[i]}, 32'hd0 + 32'(i));
    repeat (6 * CPB) @(posedge mclk);
    apb(1'b0, ST, 32'h0);
    chk(rd & 32'h60, 32'h60);
    // infrared mode both ways
    ir_mode <= 1'b1;
    apb(1'b1, CT, 32'h3);
    usd_peer_inst.send(8'h96);
    repeat (4) @(posedge mclk);
    apb(1'b0, BASE + 32'd8, 32'h0);
    chk(rd, 32'h96);
    fork
      usd_peer_inst.get(got[0]);
      apb(1'b1, usd_pkg::SLOT6_ADDR, 32'h69);
      // mid data bit 4 (a zero): infrared line low, plain line held high
      begin
        repeat (27) @(posedge mclk);
        chk({30'h0, sout, sir_out_n}, 32'h2);
      end
    join
    chk({24'h0, got[0]}, 32'h69);
    test_done;
  end
endmodule : usd_shadow_port_bench
